/* File: src/plk_pll_lock.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// RULE1 - the lock-status register is read-only by byte or by bit and writes to it are dropped.
// RULE2 - the lock-status register resets to 00H.
// RULE3 - bit 0 holds the lock flag (0 settled, 1 unsettled) and bits 7 to 1 read zero.
// RULE4 - after power-up or leaving stop the pll counts as unsettled for a stabilization interval.
// RULE5 - after deep idle release with the pll running the flag clears when the setup interval ends.
// RULE6 - the lockup-time register picks the wait used each time the run bit rises.
// RULE7 - the lockup-time register is byte read/write only, bit accesses are ignored.
// RULE8 - the lockup-time register resets to 03H.
// RULE9 - the clock-output register is byte or bit read/write.
// RULE10 - with output enable (bit 4) low the pin is held low, bits 1 and 0 pick the frequency.
// RULE11 - the flag is set on reset, in deep idle or stop, on run bit clear, and on subclock with main stopped.
// RULE12 - the flag clears on stabilization expiry after reset or stop release, or on lockup expiry.
// RULE13 - the pll control register resets to 01H: pll running, clock-through selected.
// RULE14 - software sets the run bit, waits for a zero flag, then selects pll mode.
// RULE15 - the pll stops in deep idle or stop whatever the run bit and resumes on return.
module plk_pll_lock #(
    parameter int LOCKUP_BASE = plk_pkg::LOCKUP_BASE_CYCLES
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic [31:0] BUS_ADDR,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    input wire logic BUS_BIT,
    input wire logic [2:0] BUS_BIT_POS,
    input wire logic [7:0] BUS_WDATA,
    output logic [7:0] BUS_RDATA,
    input wire logic DEEP_IDLE_MODE,
    input wire logic STOP_MODE,
    input wire logic SUBCLOCK_CPU_SELECT,
    input wire logic MAIN_CLOCK_STOP,
    input wire logic STAB_DONE,
    output logic PLL_ACTIVE,
    output logic CPU_CLOCK_PLL_SELECT,
    output logic CLOCK_OUTPUT_PIN
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] pll_control_q;
    logic [7:0] lockup_time_select_q;
    logic [7:0] clock_output_mode_q;
    logic lock_flag_q;
    logic stab_wait_q;
    logic [plk_pkg::LOCKUP_CNT_W-1:0] lockup_cnt_q;
    logic lockup_run_q;
    logic low_power_q;
    logic run_prev_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic hit_ctl, hit_lts, hit_com, hit_lock;
    logic low_power, pll_run, run_rise, run_fall;
    logic set_cond, lockup_done;
    logic [plk_pkg::LOCKUP_CNT_W-1:0] lockup_len;

    assign hit_ctl = BUS_ADDR == plk_pkg::ADDR_PLL_CONTROL;
    assign hit_lts = BUS_ADDR == plk_pkg::ADDR_LOCKUP_TIME;
    assign hit_com = BUS_ADDR == plk_pkg::ADDR_CLK_OUT_MODE;
    assign hit_lock = BUS_ADDR == plk_pkg::ADDR_LOCK_STATUS;

    assign low_power = DEEP_IDLE_MODE | STOP_MODE;
    assign pll_run = pll_control_q[plk_pkg::PLL_RUN_BIT];
    assign PLL_ACTIVE = pll_run & ~low_power; // [RULE15]
    assign run_rise = pll_run & ~run_prev_q;
    assign run_fall = ~pll_run & run_prev_q;
    assign CPU_CLOCK_PLL_SELECT = pll_control_q[plk_pkg::PLL_SELECT_BIT];

    // set conditions outrank every clear below
    assign set_cond = low_power | run_fall
        | (SUBCLOCK_CPU_SELECT & MAIN_CLOCK_STOP); // [RULE11]

    // wait grows by a factor of two per select step
    assign lockup_len = plk_pkg::LOCKUP_CNT_W'(
        LOCKUP_BASE << lockup_time_select_q[1:0]); // [RULE6]
    assign lockup_done = lockup_run_q && lockup_cnt_q >= lockup_len;

    // ------------------------------------------------------------
    // byte / bit write helper
    // ------------------------------------------------------------
    function automatic logic [7:0] wr_val(input logic [7:0] old,
        input logic [7:0] mask);
        logic [7:0] nv;
        nv = old;
        if (BUS_BIT) begin
            nv[BUS_BIT_POS] = BUS_WDATA[0];
        end else begin
            nv = BUS_WDATA;
        end
        return nv & mask;
    endfunction

    // ------------------------------------------------------------
    // pll control
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pll_control_q <= plk_pkg::RST_PLL_CONTROL; // [RULE13]
        end else if (CE && BUS_WR && hit_ctl) begin
            pll_control_q <= wr_val(pll_control_q, plk_pkg::MASK_PLL_CONTROL);
            // pll mode cannot be picked while still unsettled
            if (lock_flag_q) begin
                pll_control_q[plk_pkg::PLL_SELECT_BIT] <= 1'b0; // [RULE14]
            end
        end
    end

    // ------------------------------------------------------------
    // lockup time and clock output mode
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            lockup_time_select_q <= plk_pkg::RST_LOCKUP_TIME; // [RULE8]
        end else if (CE && BUS_WR && hit_lts && !BUS_BIT) begin
            lockup_time_select_q <= BUS_WDATA
                & plk_pkg::MASK_LOCKUP_TIME; // [RULE7]
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            clock_output_mode_q <= plk_pkg::RST_CLK_OUT_MODE;
        end else if (CE && BUS_WR && hit_com) begin
            clock_output_mode_q <= wr_val(clock_output_mode_q,
                plk_pkg::MASK_CLK_OUT_MODE); // [RULE9]
        end
    end

    // ------------------------------------------------------------
    // lockup counter
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            lockup_run_q <= 1'b0;
            lockup_cnt_q <= '0;
            run_prev_q <= 1'b1;
        end else if (CE) begin
            run_prev_q <= pll_run;
            if (set_cond || lockup_done) begin
                lockup_run_q <= 1'b0;
                lockup_cnt_q <= '0;
            end else if (run_rise) begin
                lockup_run_q <= 1'b1; // [RULE6]
                lockup_cnt_q <= '0;
            end else if (lockup_run_q) begin
                lockup_cnt_q <= lockup_cnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // lock flag
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            // the register reads 00H in reset, flag rises at release
            lock_flag_q <= 1'b0; // [RULE2]
            stab_wait_q <= 1'b1; // [RULE4]
            low_power_q <= 1'b0;
        end else if (CE) begin
            low_power_q <= low_power;
            if (low_power_q && !low_power && pll_run) begin
                stab_wait_q <= 1'b1; // [RULE4] [RULE5]
            end else if (STAB_DONE && !low_power) begin
                stab_wait_q <= 1'b0;
            end
            if (set_cond || (stab_wait_q && !STAB_DONE)) begin
                lock_flag_q <= 1'b1; // [RULE11]
            end else if ((stab_wait_q && STAB_DONE) || lockup_done) begin
                lock_flag_q <= 1'b0; // [RULE12] [RULE5]
            end
        end
    end

    // ------------------------------------------------------------
    // read port, one cycle latency
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (hit_lock) begin
            rd_byte[plk_pkg::LOCK_FLAG_BIT] = lock_flag_q; // [RULE3] [RULE1]
        end else if (hit_ctl) begin
            rd_byte = pll_control_q;
        end else if (hit_lts) begin
            rd_byte = BUS_BIT ? 8'h00 : lockup_time_select_q; // [RULE7]
        end else if (hit_com) begin
            rd_byte = clock_output_mode_q;
        end
        if (BUS_BIT) begin
            rd_byte = {7'h00, rd_byte[BUS_BIT_POS]};
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            BUS_RDATA <= 8'h00;
        end else if (CE && BUS_RD) begin
            BUS_RDATA <= rd_byte;
        end
    end

    // ------------------------------------------------------------
    // clock output
    // ------------------------------------------------------------
    plk_clk_out_div #(
        .DIV_W(4)
    ) u_div (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .enable(clock_output_mode_q[plk_pkg::CLK_OUT_EN_BIT]), // [RULE10]
        .freq_sel(clock_output_mode_q[1:0]),
        .clk_out(CLOCK_OUTPUT_PIN)
    );
endmodule // plk_pll_lock
`default_nettype wire

/* File: src/plk_pkg.sv */
package plk_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_LOCK_STATUS = 32'hFFFF_F824;
    localparam logic [31:0] ADDR_PLL_CONTROL = 32'hFFFF_F820;
    localparam logic [31:0] ADDR_LOCKUP_TIME = 32'hFFFF_F828;
    localparam logic [31:0] ADDR_CLK_OUT_MODE = 32'hFFFF_F82C;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LOCK_STATUS = 8'h00;
    localparam logic [7:0] RST_PLL_CONTROL = 8'h01;
    localparam logic [7:0] RST_LOCKUP_TIME = 8'h03;
    localparam logic [7:0] RST_CLK_OUT_MODE = 8'h00;
    // ------------------------------------------------------------
    // field positions and writable masks
    // ------------------------------------------------------------
    localparam int LOCK_FLAG_BIT = 0;
    localparam int PLL_RUN_BIT = 0;
    localparam int PLL_SELECT_BIT = 1;
    localparam int CLK_OUT_EN_BIT = 4;
    localparam logic [7:0] MASK_PLL_CONTROL = 8'h03;
    localparam logic [7:0] MASK_LOCKUP_TIME = 8'h03;
    localparam logic [7:0] MASK_CLK_OUT_MODE = 8'h13;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int LOCKUP_BASE_US = 4;
    localparam int CLK_MHZ = 250;
    localparam int LOCKUP_BASE_CYCLES = LOCKUP_BASE_US * CLK_MHZ;
    localparam int LOCKUP_CNT_W = 16;
endpackage

/* File: src/plk_clk_out_div.sv */
`timescale 1ns/1ns
`default_nettype none
module plk_clk_out_div #(
    parameter int DIV_W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic enable,
    input wire logic [1:0] freq_sel,
    output logic clk_out
);
    // ------------------------------------------------------------
    // divider: pin toggles every 2**freq_sel cycles
    // ------------------------------------------------------------
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] limit;

    assign limit = DIV_W'((1 << freq_sel) - 1);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            clk_out <= 1'b0;
        end else if (ce) begin
            // disabled output parks low, restart gives a clean first half
            if (!enable) begin
                cnt_q <= '0;
                clk_out <= 1'b0;
            end else if (cnt_q >= limit) begin
                cnt_q <= '0;
                clk_out <= ~clk_out;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule // plk_clk_out_div
`default_nettype wire

/* File: dv/plk_pll_lock_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module plk_pll_lock_chk (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic [31:0] BUS_ADDR,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    input wire logic BUS_BIT,
    input wire logic [2:0] BUS_BIT_POS,
    input wire logic [7:0] BUS_WDATA,
    input wire logic [7:0] BUS_RDATA,
    input wire logic DEEP_IDLE_MODE,
    input wire logic STOP_MODE,
    input wire logic PLL_ACTIVE,
    input wire logic CPU_CLOCK_PLL_SELECT,
    input wire logic CLOCK_OUTPUT_PIN
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wire logic rd = CE && BUS_RD;
    wire logic low_pwr = DEEP_IDLE_MODE || STOP_MODE;
    wire logic at_lock = BUS_ADDR == plk_pkg::ADDR_LOCK_STATUS;
    rd_lock_a: assert property (
        rd && at_lock |=> BUS_RDATA[7:1] == 7'h00
    ) else $error("lock status upper bits not zero");
    bit_lock_a: assert property (
        rd && at_lock && BUS_BIT && BUS_BIT_POS != 3'h0 |=> BUS_RDATA == 8'h00
    ) else $error("lock status bit read not zero");
    bit_lkt_a: assert property (
        rd && BUS_BIT && BUS_ADDR == plk_pkg::ADDR_LOCKUP_TIME
        |=> BUS_RDATA == 8'h00
    ) else $error("lockup time answered a bit read");
    lp_flag_a: assert property (
        rd && at_lock && !BUS_BIT && low_pwr && $past(low_pwr)
        && !$past(SYS_RST) |=> BUS_RDATA == 8'h01
    ) else $error("lock flag clear in low power mode");
    pll_stop_a: assert property (
        low_pwr |-> !PLL_ACTIVE
    ) else $error("pll active in low power mode");
    rd_hold_a: assert property (
        !rd |=> $stable(BUS_RDATA)
    ) else $error("read data moved without a read");
    sel_rise_a: assert property (
        $rose(CPU_CLOCK_PLL_SELECT) |-> $past(BUS_WR) || $past(BUS_WR, 2)
    ) else $error("pll select rose without a write");
    pin_off_a: assert property (
        CE && BUS_WR && !BUS_BIT && !BUS_WDATA[4]
        && BUS_ADDR == plk_pkg::ADDR_CLK_OUT_MODE |=> ##1 !CLOCK_OUTPUT_PIN
    ) else $error("clock pin not low when disabled");
endmodule // plk_pll_lock_chk
bind plk_pll_lock plk_pll_lock_chk u_chk (.CLK, .SYS_RST, .CE, .BUS_ADDR,
    .BUS_WR, .BUS_RD, .BUS_BIT, .BUS_BIT_POS, .BUS_WDATA, .BUS_RDATA,
    .DEEP_IDLE_MODE, .STOP_MODE, .PLL_ACTIVE, .CPU_CLOCK_PLL_SELECT,
    .CLOCK_OUTPUT_PIN);
`default_nettype wire

/* File: dv/plk_pll_lock_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module plk_pll_lock_bench;
    localparam int BASE = 4;
    logic CLK, SYS_RST, CE, BUS_WR, BUS_RD, BUS_BIT, DEEP_IDLE_MODE, STOP_MODE;
    logic SUBCLOCK_CPU_SELECT, MAIN_CLOCK_STOP, STAB_DONE, PLL_ACTIVE;
    logic CPU_CLOCK_PLL_SELECT, CLOCK_OUTPUT_PIN;
    logic [31:0] BUS_ADDR;
    logic [2:0] BUS_BIT_POS;
    logic [7:0] BUS_WDATA, BUS_RDATA, got, d;
    logic [31:0] rs = 32'h0000_0011;
    int n_fail = 0, compares = 0, cyc = 0, t0;
    // shadow model of the lockup-time and clock-output registers, kept from the rules alone
    int m_lts = plk_pkg::RST_LOCKUP_TIME;
    int m_com = plk_pkg::RST_CLK_OUT_MODE;
    plk_pll_lock #(.LOCKUP_BASE(BASE)) dut (.CLK, .SYS_RST, .CE, .BUS_ADDR,
        .BUS_WR, .BUS_RD, .BUS_BIT, .BUS_BIT_POS, .BUS_WDATA, .BUS_RDATA,
        .DEEP_IDLE_MODE, .STOP_MODE, .SUBCLOCK_CPU_SELECT, .MAIN_CLOCK_STOP,
        .STAB_DONE, .PLL_ACTIVE, .CPU_CLOCK_PLL_SELECT, .CLOCK_OUTPUT_PIN);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        CLK = 0;
        forever #2 CLK = ~CLK;
    end
    always @(posedge CLK) cyc <= cyc + 1;
    function automatic logic [7:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[7:0];
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    // strobes drop at the answer edge, so back to back calls never overlap
    task automatic acc(input logic w, input logic [31:0] a, input logic b,
                       input logic [2:0] p, input logic [7:0] v);
        @(posedge CLK);
        BUS_WR <= w;
        BUS_RD <= !w;
        BUS_ADDR <= a;
        BUS_BIT <= b;
        BUS_BIT_POS <= p;
        BUS_WDATA <= v;
        @(posedge CLK);
        BUS_WR <= 1'b0;
        BUS_RD <= 1'b0;
        #1 got = BUS_RDATA;
        // a frozen clock enable drops the write, so the model skips it too
        if (w && CE && a == plk_pkg::ADDR_CLK_OUT_MODE) begin
            if (b)
                m_com[p] = v[0];
            else
                m_com = int'(v);
            m_com = m_com & int'(plk_pkg::MASK_CLK_OUT_MODE);
        end
        if (w && CE && !b && a == plk_pkg::ADDR_LOCKUP_TIME)
            m_lts = int'(v & plk_pkg::MASK_LOCKUP_TIME);
    endtask
    task automatic rdc(input logic [31:0] a, input logic b, input logic [2:0] p,
                       input logic [7:0] e);
        acc(1'b0, a, b, p, 8'h00);
        chk(got, e);
        if (a == plk_pkg::ADDR_LOCKUP_TIME)
            chk(got, b ? 8'h00 : 8'(m_lts));
        if (a == plk_pkg::ADDR_CLK_OUT_MODE)
            chk(got, b ? 8'((m_com >> p) & 1) : 8'(m_com));
    endtask
    task automatic stab();
        @(posedge CLK);
        STAB_DONE <= 1'b1;
        @(posedge CLK);
        STAB_DONE <= 1'b0;
    endtask
    // polls the flag; read latency adds a few cycles of slack
    task automatic lock_wait(input int lo);
        got = 8'h01;
        for (int i = 0; i < 100 && got !== 8'h00; i++)
            acc(1'b0, plk_pkg::ADDR_LOCK_STATUS, 1'b0, 3'h0, 8'h00);
        chk({7'h00, cyc - t0 >= lo && cyc - t0 <= lo + 6}, 8'h01);
    endtask
    task automatic pin_gap(input int p);
        logic v;
        int t;
        repeat (3) @(posedge CLK);
        #1 v = CLOCK_OUTPUT_PIN;
        for (int i = 0; i < 40 && CLOCK_OUTPUT_PIN === v; i++) begin
            @(posedge CLK);
            #1;
        end
        t = cyc;
        v = CLOCK_OUTPUT_PIN;
        for (int i = 0; i < 40 && CLOCK_OUTPUT_PIN === v; i++) begin
            @(posedge CLK);
            #1;
        end
        chk({7'h00, cyc - t == p}, 8'h01);
    endtask
    task automatic report_and_stop();
        $display("n_fail=%0d compares=%0d", n_fail, compares);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        {BUS_WR, BUS_RD, BUS_BIT, DEEP_IDLE_MODE, STOP_MODE, STAB_DONE} = 6'h00;
        {SUBCLOCK_CPU_SELECT, MAIN_CLOCK_STOP} = 2'h0;
        {BUS_ADDR, BUS_BIT_POS, BUS_WDATA} = 43'h000_0000_0000;
        CE = 1'b1;
        SYS_RST = 1'b1;
        repeat (3) @(posedge CLK);
        #1 chk(BUS_RDATA, 8'h00);
        @(posedge CLK);
        SYS_RST <= 1'b0;
        rdc(plk_pkg::ADDR_LOCK_STATUS, 1'b0, 3'h0, 8'h01);
        rdc(plk_pkg::ADDR_LOCKUP_TIME, 1'b0, 3'h0, 8'h03);
        rdc(plk_pkg::ADDR_PLL_CONTROL, 1'b0, 3'h0, 8'h01);
        rdc(plk_pkg::ADDR_CLK_OUT_MODE, 1'b0, 3'h0, 8'h00);
        rdc(32'hFFFF_F830, 1'b0, 3'h0, 8'h00);
        acc(1'b1, plk_pkg::ADDR_PLL_CONTROL, 1'b0, 3'h0, 8'h03);
        rdc(plk_pkg::ADDR_PLL_CONTROL, 1'b0, 3'h0, 8'h01);
        stab();
        rdc(plk_pkg::ADDR_LOCK_STATUS, 1'b0, 3'h0, 8'h00);
        acc(1'b1, plk_pkg::ADDR_LOCK_STATUS, 1'b0, 3'h0, 8'hFF);
        acc(1'b1, plk_pkg::ADDR_LOCK_STATUS, 1'b1, 3'h0, 8'h01);
        rdc(plk_pkg::ADDR_LOCK_STATUS, 1'b0, 3'h0, 8'h00);
        rdc(plk_pkg::ADDR_LOCK_STATUS, 1'b1, 3'h3, 8'h00);
        acc(1'b1, plk_pkg::ADDR_PLL_CONTROL, 1'b0, 3'h0, 8'h03);
        chk({7'h00, CPU_CLOCK_PLL_SELECT}, 8'h01);
        acc(1'b1, plk_pkg::ADDR_PLL_CONTROL, 1'b0, 3'h0, 8'h01);
        for (int s = 0; s < 4; s++) begin
            acc(1'b1, plk_pkg::ADDR_LOCKUP_TIME, 1'b1, 3'h2, 8'h01);
            d = (rnd() & 8'hFC) | 8'(s);
            acc(1'b1, plk_pkg::ADDR_LOCKUP_TIME, 1'b0, 3'h0, d);
            rdc(plk_pkg::ADDR_LOCKUP_TIME, 1'b1, 3'h0, 8'h00);
            rdc(plk_pkg::ADDR_LOCKUP_TIME, 1'b0, 3'h0, 8'(s));
            acc(1'b1, plk_pkg::ADDR_PLL_CONTROL, 1'b0, 3'h0, 8'h00);
            rdc(plk_pkg::ADDR_LOCK_STATUS, 1'b0, 3'h0, 8'h01);
            acc(1'b1, plk_pkg::ADDR_PLL_CONTROL, 1'b0, 3'h0, 8'h01);
            t0 = cyc;
            lock_wait(BASE << s);
        end
        for (int m = 0; m < 2; m++) begin
            @(posedge CLK);
            DEEP_IDLE_MODE <= (m == 0);
            STOP_MODE <= (m == 1);
            repeat (2) @(posedge CLK);
            rdc(plk_pkg::ADDR_LOCK_STATUS, 1'b0, 3'h0, 8'h01);
            chk({7'h00, PLL_ACTIVE}, 8'h00);
            @(posedge CLK);
            {DEEP_IDLE_MODE, STOP_MODE} <= 2'h0;
            stab();
            rdc(plk_pkg::ADDR_LOCK_STATUS, 1'b0, 3'h0, 8'h00);
            chk({7'h00, PLL_ACTIVE}, 8'h01);
        end
        @(posedge CLK);
        {SUBCLOCK_CPU_SELECT, MAIN_CLOCK_STOP} <= 2'h3;
        repeat (2) @(posedge CLK);
        rdc(plk_pkg::ADDR_LOCK_STATUS, 1'b0, 3'h0, 8'h01);
        @(posedge CLK);
        {SUBCLOCK_CPU_SELECT, MAIN_CLOCK_STOP} <= 2'h0;
        acc(1'b1, plk_pkg::ADDR_PLL_CONTROL, 1'b0, 3'h0, 8'h00);
        acc(1'b1, plk_pkg::ADDR_PLL_CONTROL, 1'b0, 3'h0, 8'h01);
        t0 = cyc;
        lock_wait(BASE << 3);
        for (int s = 0; s < 4; s++) begin
            acc(1'b1, plk_pkg::ADDR_CLK_OUT_MODE, 1'b0, 3'h0, 8'h10 | 8'(s));
            rdc(plk_pkg::ADDR_CLK_OUT_MODE, 1'b0, 3'h0, 8'h10 | 8'(s));
            pin_gap(1 << s);
        end
        acc(1'b1, plk_pkg::ADDR_CLK_OUT_MODE, 1'b1, 3'h4, 8'h00);
        rdc(plk_pkg::ADDR_CLK_OUT_MODE, 1'b1, 3'h4, 8'h00);
        repeat (8) begin
            @(posedge CLK);
            #1 chk({7'h00, CLOCK_OUTPUT_PIN}, 8'h00);
        end
        acc(1'b1, plk_pkg::ADDR_CLK_OUT_MODE, 1'b1, 3'h4, 8'h01);
        rdc(plk_pkg::ADDR_CLK_OUT_MODE, 1'b0, 3'h0, 8'h13);
        // clock enable low: a write and a read are both dropped
        @(posedge CLK);
        CE <= 1'b0;
        acc(1'b1, plk_pkg::ADDR_CLK_OUT_MODE, 1'b0, 3'h0, 8'h00);
        acc(1'b0, plk_pkg::ADDR_LOCKUP_TIME, 1'b0, 3'h0, 8'h00);
        chk(got, 8'h13);
        @(posedge CLK);
        CE <= 1'b1;
        rdc(plk_pkg::ADDR_CLK_OUT_MODE, 1'b0, 3'h0, 8'h13);
        repeat (6) begin
            d = rnd();
            acc(1'b1, plk_pkg::ADDR_CLK_OUT_MODE, 1'b0, 3'h0, d);
            rdc(plk_pkg::ADDR_CLK_OUT_MODE, 1'b0, 3'h0, d & 8'h13);
        end
        report_and_stop();
    end
endmodule // plk_pll_lock_bench
`default_nettype wire
